//--- hdl/adc_host_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADC_HOST_DEFS_SVH
`define ADC_HOST_DEFS_SVH
`define REG_RESULT 2'h0
`define REG_GAIN 2'h1
`define REG_OFFSET 2'h2
`define REG_CONTROL 2'h3
`define REG_RESET 14'h0000
`define CTL_SLEEP 13
`define CTL_EXTREF 12
`define CTL_TWOS 11
`define CTL_CHECK_HI 10
`define CTL_CHECK_LO 8
`define CTL_NO_CORR 7
`define CTL_IRQ_POL 6
`define CTL_OVR_POL 5
`define CTL_FIFO_ON 4
`define CTL_THR_HI 3
`define CTL_THR_LO 0
`define GAIN_HI 2
`define OFFS_HI 7
`define LATENCY_HALF_CYCLES 19
`define MSB_FLIP 14'h2000
`define CODE_MAX 15'sh3fff
`define CODE_MIN 15'sh0000
`endif

//--- hdl/adc_host_pkg.sv
// types shared by the converter host block
package adc_host_pkg;
  typedef struct packed {
    logic sleep;
    logic ext_ref;
    logic twos;
    logic [2:0] check;
    logic no_corr;
    logic irq_pol;
    logic ovr_pol;
    logic fifo_on;
    logic [3:0] thr;
  } ctrl_t;
  typedef struct packed {
    logic [1:0] sel;
    logic [13:0] data;
  } host_wr_t;
  typedef enum logic [1:0] {check_normal, check_low_bias, check_high_bias, check_fixed} check_mode_t;
endpackage

//--- hdl/sync_edge.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
module sync_edge (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign level = sync_ff;
  assign rise = sync_ff & ~last_ff;
  assign fall = ~sync_ff & last_ff;
endmodule // sync_edge

//--- hdl/adc_fifo_host_interface.sv
// host interface of the converter: result fifo, register map, flags
`timescale 1ns/10ps
`include "adc_host_defs.svh"
module adc_fifo_host_interface import adc_host_pkg::*; #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sample_tick,
  input wire logic [13:0] core_code,
  input wire logic [1:0] reg_sel,
  input wire logic [13:0] data_in,
  input wire logic unit_sel_n,
  input wire logic out_en_n,
  input wire logic wr_strobe_n,
  output logic [13:0] data_out,
  output logic data_oe,
  output logic irq_out,
  output logic fifo_overrun_flag,
  output logic overrun_status,
  output logic sleep_out,
  output logic ext_ref_out,
  output logic [2:0] gain_step_field,
  output logic [2:0] core_check_field,
  output logic [1:0] check_mode
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] sel_m_ff, sel_s_ff;
  logic [13:0] din_m_ff, din_s_ff;
  logic cs_m_ff, cs_s_ff;
  logic oe_lvl, oe_rise, wr_rise;
  sync_edge u_oe (
    .clk(sys_clk),
    .reset(reset),
    .async_in(~out_en_n),
    .level(oe_lvl),
    .rise(oe_rise),
    .fall()
  );
  // inverted so the idle pin matches the flop reset level: no false edge after reset
  sync_edge u_wr (
    .clk(sys_clk),
    .reset(reset),
    .async_in(~wr_strobe_n),
    .level(),
    .rise(),
    .fall(wr_rise)
  );
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sel_m_ff <= 2'h0;
      sel_s_ff <= 2'h0;
      din_m_ff <= 14'h0;
      din_s_ff <= 14'h0;
      cs_m_ff <= 1'b0;
      cs_s_ff <= 1'b0;
    end else begin
      sel_m_ff <= reg_sel;
      sel_s_ff <= sel_m_ff;
      din_m_ff <= data_in;
      din_s_ff <= din_m_ff;
      cs_m_ff <= ~unit_sel_n;
      cs_s_ff <= cs_m_ff;
    end
  end
  // ==========================================================
  // registers
  logic [13:0] gain_ff, offs_ff;
  ctrl_t ctrl_ff;
  host_wr_t wr;
  assign wr = '{sel: sel_s_ff, data: din_s_ff};
  // hold lines are slow against 50 ns sampling; strobe edge latches them
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gain_ff <= `REG_RESET;
      offs_ff <= `REG_RESET;
      ctrl_ff <= ctrl_t'(`REG_RESET);
    end else if (wr_rise && cs_s_ff) begin
      unique case (wr.sel)
        `REG_GAIN: gain_ff <= wr.data;
        `REG_OFFSET: offs_ff <= wr.data;
        `REG_CONTROL: ctrl_ff <= ctrl_t'(wr.data);
        `REG_RESULT: ;
      endcase
    end
  end
  // ==========================================================
  // conversion pipeline, half-cycle latency counted on sys_clk
  logic [4:0] tick_div_ff;
  logic half_tick;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) tick_div_ff <= 5'h0;
    else if (sample_tick) tick_div_ff <= 5'h0;
    else tick_div_ff <= tick_div_ff + 5'h1;
  end
  // second half-slot enable; sample period measured by the previous frame
  logic [4:0] period_ff;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) period_ff <= 5'h2;
    else if (sample_tick) period_ff <= tick_div_ff + 5'h1;
  end
  assign half_tick = sample_tick || (tick_div_ff == (period_ff >> 1) - 5'h1 && !sample_tick);
  logic [13:0] pipe_ff [`LATENCY_HALF_CYCLES];
  logic [`LATENCY_HALF_CYCLES-1:0] pvld_ff;
  logic [13:0] sample_code;
  always_comb begin
    sample_code = core_code;
    unique case (ctrl_ff.check)
      3'b001: sample_code = 14'h0000;
      3'b101: sample_code = 14'h2000;
      3'b010: sample_code = 14'h1000;
      3'b011: sample_code = 14'h3fff;
      3'b110: sample_code = 14'h1000;
      3'b111: sample_code = 14'h0000;
      default: sample_code = core_code;
    endcase
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pvld_ff <= '0;
      for (int i = 0; i < `LATENCY_HALF_CYCLES; i++) pipe_ff[i] <= 14'h0;
    end else if (half_tick) begin
      pipe_ff[0] <= sample_code;
      pvld_ff[0] <= sample_tick && !ctrl_ff.sleep;
      for (int i = 1; i < `LATENCY_HALF_CYCLES; i++) begin
        pipe_ff[i] <= pipe_ff[i-1];
        pvld_ff[i] <= pvld_ff[i-1];
      end
    end
  end
  logic res_vld;
  assign res_vld = half_tick && pvld_ff[`LATENCY_HALF_CYCLES-1];
  // ==========================================================
  // offset correction and code format
  logic signed [14:0] corr;
  logic signed [14:0] raw_s;
  logic [13:0] res_code;
  always_comb begin
    raw_s = signed'({1'b0, pipe_ff[`LATENCY_HALF_CYCLES-1]});
    corr = raw_s;
    if (!ctrl_ff.no_corr) begin
      corr = raw_s + 15'(signed'(offs_ff[`OFFS_HI:0]));
    end
    if (corr > `CODE_MAX) corr = `CODE_MAX;
    if (corr < `CODE_MIN) corr = `CODE_MIN;
    res_code = corr[13:0];
    if (ctrl_ff.twos) res_code = corr[13:0] ^ `MSB_FLIP;
  end
  // ==========================================================
  // result fifo
  logic [13:0] mem [DEPTH];
  logic [AW-1:0] wptr_ff, rptr_ff;
  logic [AW:0] count_ff;
  logic [13:0] direct_ff;
  logic pop, push, full;
  assign pop = oe_rise && sel_s_ff == `REG_RESULT && cs_s_ff && count_ff != '0;
  assign push = res_vld && ctrl_ff.fifo_on;
  assign full = count_ff == (AW+1)'(DEPTH);
  always_ff @(posedge sys_clk) begin
    if (push) mem[wptr_ff] <= res_code;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end else if (!ctrl_ff.fifo_on) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end else begin
      // on overflow the oldest sample is overwritten and read pointer follows
      if (push) wptr_ff <= wptr_ff + AW'(1);
      if (pop || (push && full)) rptr_ff <= rptr_ff + AW'(1);
      if (push && !pop && !full) count_ff <= count_ff + (AW+1)'(1);
      else if (pop && !push) count_ff <= count_ff - (AW+1)'(1);
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) direct_ff <= 14'h0;
    else if (res_vld) direct_ff <= res_code;
  end
  // ==========================================================
  // interrupt and overrun
  logic [AW:0] thresh;
  logic level_hit, ovr_ff, irq_lvl_ff;
  assign thresh = (AW+1)'({ctrl_ff.thr, 1'b0});
  assign level_hit = ctrl_ff.fifo_on && count_ff >= thresh;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) irq_lvl_ff <= 1'b0;
    // a pop that leaves fewer than threshold clears at once
    else if (pop && !push && count_ff <= thresh) irq_lvl_ff <= 1'b0;
    else if (level_hit) irq_lvl_ff <= 1'b1;
    else if (pop || !ctrl_ff.fifo_on) irq_lvl_ff <= 1'b0;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) ovr_ff <= 1'b0;
    else if (push && full) ovr_ff <= 1'b1;
    else if (!ctrl_ff.fifo_on) ovr_ff <= 1'b0;
  end
  // ==========================================================
  // read mux and outputs
  logic [13:0] rd_mux;
  always_comb begin
    unique case (sel_s_ff)
      `REG_RESULT: rd_mux = ctrl_ff.fifo_on ? mem[rptr_ff] : direct_ff;
      `REG_GAIN: rd_mux = gain_ff;
      `REG_OFFSET: rd_mux = offs_ff;
      `REG_CONTROL: rd_mux = 14'(ctrl_ff);
    endcase
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_out <= 14'h0;
      data_oe <= 1'b0;
      irq_out <= 1'b1;
      fifo_overrun_flag <= 1'b1;
      overrun_status <= 1'b0;
      sleep_out <= 1'b0;
      ext_ref_out <= 1'b0;
      gain_step_field <= 3'h0;
      core_check_field <= 3'h0;
      check_mode <= 2'h0;
    end else begin
      data_out <= rd_mux;
      data_oe <= oe_lvl && cs_s_ff;
      irq_out <= irq_lvl_ff ~^ ctrl_ff.irq_pol;
      fifo_overrun_flag <= ovr_ff ~^ ctrl_ff.ovr_pol;
      overrun_status <= ovr_ff;
      sleep_out <= ctrl_ff.sleep;
      ext_ref_out <= ctrl_ff.ext_ref;
      gain_step_field <= gain_ff[`GAIN_HI:0];
      core_check_field <= ctrl_ff.check;
      unique case (ctrl_ff.check[1:0])
        2'b00: check_mode <= check_normal;
        2'b01: check_mode <= ctrl_ff.check[2] ? check_high_bias : check_low_bias;
        default: check_mode <= check_fixed;
      endcase
    end
  end
endmodule // adc_fifo_host_interface

//--- dv/adc_host_monitor.sv
// port assertions for the converter host interface
`timescale 1ns/10ps
module adc_host_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic unit_sel_n,
  input wire logic out_en_n,
  input wire logic wr_strobe_n,
  input wire logic data_oe,
  input wire logic fifo_overrun_flag,
  input wire logic overrun_status,
  input wire logic sleep_out,
  input wire logic ext_ref_out,
  input wire logic [2:0] gain_step_field,
  input wire logic [2:0] core_check_field,
  input wire logic [1:0] check_mode
);
  // ====
  // checks
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  AST_OE_IDLE:
    assert property (out_en_n [*5] |-> !data_oe) else $error("oe idle");
  AST_CS_IDLE:
    assert property (unit_sel_n [*5] |-> !data_oe) else $error("cs idle");
  AST_OE_ON:
    assert property ((!out_en_n && !unit_sel_n) [*5] |-> data_oe) else $error("oe on");
  AST_OE_CAUSE:
    assert property ($rose(data_oe) |-> !$past(out_en_n, 2) && !$past(unit_sel_n, 2)) else $error("oe cause");
  AST_CFG_HOLD:
    assert property (wr_strobe_n [*8] |-> $stable({sleep_out, ext_ref_out, gain_step_field, core_check_field}))
    else $error("cfg moved");
  AST_RESET_CLEAR:
    assert property ($fell(reset) |-> {sleep_out, ext_ref_out, gain_step_field, core_check_field} == 8'h00)
    else $error("reset value");
  AST_OVR_FLAG:
    assert property ($rose(overrun_status) |-> ##[0:1] $changed(fifo_overrun_flag)) else $error("overrun flag");
  AST_CHECK_DECODE:
    assert property ($stable(core_check_field) |-> check_mode == (core_check_field[1] ? 2'h3 :
      core_check_field[0] ? {core_check_field[2], !core_check_field[2]} : 2'h0)) else $error("check decode");
endmodule  // adc_host_monitor
bind adc_fifo_host_interface adc_host_monitor adc_host_monitor_inst (.sys_clk, .reset, .unit_sel_n, .out_en_n,
  .wr_strobe_n, .data_oe, .fifo_overrun_flag, .overrun_status, .sleep_out, .ext_ref_out, .gain_step_field,
  .core_check_field, .check_mode);

//--- dv/host_model.sv
// host processor model for the parallel register bus
`timescale 1ns/10ps
module host_model (
  input wire logic sys_clk,
  input wire logic [13:0] data_out,
  input wire logic data_oe,
  output logic [1:0] reg_sel,
  output logic [13:0] data_in,
  output logic unit_sel_n,
  output logic out_en_n,
  output logic wr_strobe_n
);
  // ====
  // bus cycles, pins move only at falling edges
  initial begin
    reg_sel = 2'h0;
    data_in = 14'h0;
    unit_sel_n = 1'b1;
    out_en_n = 1'b1;
    wr_strobe_n = 1'b1;
  end
  // four-cycle phases since the pins pass a synchroniser
  task automatic wr(input logic [1:0] s, input logic [13:0] d);
    @(negedge sys_clk);
    reg_sel = s;
    data_in = d;
    unit_sel_n = 1'b0;
    wr_strobe_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr_strobe_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    unit_sel_n = 1'b1;
    data_in = ~d;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [1:0] s, output logic [13:0] d);
    @(negedge sys_clk);
    reg_sel = s;
    unit_sel_n = 1'b0;
    out_en_n = 1'b0;
    for (int i = 0; i < 10 && data_oe !== 1'b1; i++)
      @(negedge sys_clk);
    d = data_out;
    repeat (3) @(negedge sys_clk);
    out_en_n = 1'b1;
    unit_sel_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule  // host_model

//--- dv/adc_fifo_host_interface_tb.sv
// self-checking bench for the converter host interface
`timescale 1ns/10ps
module adc_fifo_host_interface_tb import adc_host_pkg::*;;
  typedef struct packed {logic [13:0] ctl, offs, code, res;} conv_row_t;
  logic sys_clk = 1'b0, reset = 1'b1, sample_tick = 1'b0, tick_en = 1'b1, ramp = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic [13:0] core_code = 14'h0;
  logic [1:0] reg_sel, check_mode;
  logic [13:0] data_in, data_out, rv, prev;
  logic unit_sel_n, out_en_n, wr_strobe_n, data_oe, irq_out, fifo_overrun_flag, overrun_status;
  logic sleep_out, ext_ref_out;
  logic [2:0] gain_step_field, core_check_field;
  int err_total = 0, checked = 0, n;
  // fifo bypassed: control, offset, raw code, expected word
  conv_row_t rows [7] = '{'{14'h0000, 14'h0000, 14'h1234, 14'h1234}, '{14'h0800, 14'h0000, 14'h0000, 14'h2000},
    '{14'h0800, 14'h0000, 14'h3fff, 14'h1fff}, '{14'h0800, 14'h0000, 14'h2000, 14'h0000},
    '{14'h0000, 14'h0010, 14'h1000, 14'h1010}, '{14'h0080, 14'h0010, 14'h1000, 14'h1000},
    '{14'h0000, 14'h00f0, 14'h0100, 14'h00f0}};
  adc_fifo_host_interface #(.DEPTH(32), .AW(5)) adc_fifo_host_interface_inst (.sys_clk, .reset, .sample_tick,
    .core_code, .reg_sel, .data_in, .unit_sel_n, .out_en_n, .wr_strobe_n, .data_out, .data_oe, .irq_out,
    .fifo_overrun_flag, .overrun_status, .sleep_out, .ext_ref_out, .gain_step_field, .core_check_field, .check_mode);
  host_model host_model_inst (.sys_clk, .data_out, .data_oe, .reg_sel, .data_in, .unit_sel_n, .out_en_n,
    .wr_strobe_n);
  // ====
  // stimulus and checking
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    sample_tick <= tick_en && tick_cnt == 2'h0;
    if (ramp && sample_tick) begin
      core_code <= core_code + 14'h1;
    end
  end
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    for (int s = 1; s < 4; s++) begin
      host_model_inst.rd(2'(s), rv);
      check(rv, 14'h0);
    end
    host_model_inst.wr(2'h1, 14'h0005);
    host_model_inst.rd(2'h1, rv);
    check(rv, 14'h0005);
    check({11'h0, gain_step_field}, 14'h5);
    foreach (rows[i]) begin
      host_model_inst.wr(2'h2, rows[i].offs);
      host_model_inst.wr(2'h3, rows[i].ctl);
      core_code = rows[i].code;
      repeat (60) @(negedge sys_clk);
      host_model_inst.rd(2'h0, rv);
      check(rv, rows[i].res);
      host_model_inst.rd(2'h3, rv);
      check(rv, rows[i].ctl);
    end
    for (int c = 0; c < 8; c++) begin
      host_model_inst.wr(2'h3, {2'h3, 1'b0, 3'(c), 8'h0});
      repeat (2) @(negedge sys_clk);
      check({7'h0, sleep_out, ext_ref_out, core_check_field, check_mode},
        {9'h3, 3'(c), (c % 4 == 0) ? 2'h0 : (c & 2) ? 2'h3 : (c > 4) ? 2'h2 : 2'h1});
    end
    // fill past the depth so the fifo overruns
    ramp = 1'b1;
    host_model_inst.wr(2'h3, 14'h0071);
    repeat (200) @(negedge sys_clk);
    check({11'h0, irq_out, overrun_status, fifo_overrun_flag}, 14'h7);
    host_model_inst.wr(2'h3, 14'h0011);
    repeat (2) @(negedge sys_clk);
    check({12'h0, irq_out, fifo_overrun_flag}, 14'h0);
    tick_en = 1'b0;
    // let the conversion pipeline drain before popping
    repeat (700) @(negedge sys_clk);
    host_model_inst.rd(2'h0, prev);
    n = 1;
    while (irq_out === 1'b0 && n < 40) begin
      host_model_inst.rd(2'h0, rv);
      check(rv, prev + 14'h1);
      prev = rv;
      n++;
    end
    check((n < 40) ? 14'h1 : 14'h0, 14'h1);
    tally_and_finish();
  end
endmodule  // adc_fifo_host_interface_tb
